// ==== verilog/pss_pkg.sv ====
// Constants for the pump staging relay sequencer.
// Assumes a single 40 MHz system clock and times given in tenths of a second.
package pss_pkg;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int TENTH_NS = 100000000;
    localparam int CLK_NS = 25;
    localparam int TICKS_PER_TENTH_DEF = TENTH_NS / CLK_NS;
    localparam logic [12:0] DWELL_MIN = 13'h000A;
    localparam logic [12:0] DWELL_MAX = 13'h1770;
    localparam logic [12:0] CHG_MIN = 13'h0001;
    localparam logic [12:0] CHG_MAX = 13'h00C8;
    localparam int TIME_W = 13;
    // -------------------------------------------------------------------
    // Modes
    // -------------------------------------------------------------------
    localparam logic MODE_CYCLE = 1'b0;
    localparam logic MODE_ONE_TO_THREE = 1'b1;
    typedef enum logic [2:0] {
        PSS_IDLE,
        PSS_ADD_WAIT1,
        PSS_ADD_WAIT2,
        PSS_REM_WAIT
    } pss_state_e;
endpackage

// ==== verilog/pss_sequencer.sv ====
// Pump staging relay sequencer: adds and removes pumps by relay outputs.
// Assumes at_upper and at_lower come from the frequency loop on clk_sys.
//
// Overview of operation
// - Upper dwell expired: drop relay 1 and suppress output frequency.
// - Cycle mode: then energise relays 1 and 2, accelerate after change-over wait.
// - Cycle mode: lower dwell expired drops relays 1 and 2.
// - Cycle mode: after change-over wait re-energise relay 1, then decelerate.
// - One-to-three: after wait energise relay 2, output still suppressed.
// - One-to-three: after second wait energise relay 1, then accelerate.
// - Lower output frequency when pressure feedback exceeds target, unless output is suppressed.
// - One-to-three: lower dwell expired drops relay 1.
// - One-to-three: relays 1 to 3 map onto the three board relay outputs.
// - Dwell times range 1.0 to 600.0 seconds and govern staging.
// - With zero bias, frequency must reach the limit before dwell counts.
// - One-to-three mode leaves expansion-card relays unused.
`timescale 1ns/100ps
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int TICKS_PER_TENTH = TICKS_PER_TENTH_DEF
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mode_one_to_three,
    input wire logic [TIME_W-1:0] upper_dwell,
    input wire logic [TIME_W-1:0] lower_dwell,
    input wire logic [TIME_W-1:0] change_wait,
    input wire logic at_upper,
    input wire logic at_lower,
    input wire logic pressure_above_target,
    output logic [2:0] board_relay_outputs,
    output logic [3:0] card_relay_outputs,
    output logic output_suppress,
    output logic accel_req,
    output logic decel_req,
    output logic busy
);
    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [TIME_W-1:0] clamp_t(input logic [TIME_W-1:0] v, input logic [TIME_W-1:0] lo,
                                                   input logic [TIME_W-1:0] hi);
        clamp_t = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // -------------------------------------------------------------------
    // Tenth-second prescaler
    // -------------------------------------------------------------------
    logic [31:0] pre_q, pre_d;
    logic tenth;
    always_comb begin
        tenth = (pre_q == 32'(TICKS_PER_TENTH - 1));
        pre_d = tenth ? 32'h0000_0000 : pre_q + 32'h0000_0001;
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= pre_d;
        end
    end

    // -------------------------------------------------------------------
    // Dwell timers
    // -------------------------------------------------------------------
    logic [TIME_W-1:0] up_cnt_q, up_cnt_d, lo_cnt_q, lo_cnt_d;
    logic up_exp, lo_exp;
    pss_state_e st_q, st_d;
    always_comb begin
        // The limit flags already include any switching bias, so a zero bias means the exact limit.
        up_cnt_d = up_cnt_q;
        lo_cnt_d = lo_cnt_q;
        if (!at_upper || st_q != PSS_IDLE) begin
            up_cnt_d = '0;
        end else if (tenth && !up_exp) begin
            up_cnt_d = up_cnt_q + 1'b1;
        end
        if (!at_lower || st_q != PSS_IDLE) begin
            lo_cnt_d = '0;
        end else if (tenth && !lo_exp) begin
            lo_cnt_d = lo_cnt_q + 1'b1;
        end
    end
    // Strictly longer than the dwell: one extra tenth must pass.
    assign up_exp = up_cnt_q > clamp_t(upper_dwell, DWELL_MIN, DWELL_MAX);
    assign lo_exp = lo_cnt_q > clamp_t(lower_dwell, DWELL_MIN, DWELL_MAX);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            up_cnt_q <= '0;
            lo_cnt_q <= '0;
        end else begin
            up_cnt_q <= up_cnt_d;
            lo_cnt_q <= lo_cnt_d;
        end
    end

    // -------------------------------------------------------------------
    // Staging sequence
    // -------------------------------------------------------------------
    logic [TIME_W-1:0] wt_q, wt_d;
    logic [2:0] rly_q, rly_d;
    logic sup_q, sup_d, acc_q, acc_d, dec_q, dec_d;
    logic wait_done;
    // The prescaler runs free, so the first tenth of a wait may be partial.
    // Counting one tick past the setting makes sure the whole wait elapses.
    assign wait_done = tenth && (wt_q >= clamp_t(change_wait, CHG_MIN, CHG_MAX));
    always_comb begin
        st_d = st_q;
        rly_d = rly_q;
        sup_d = sup_q;
        acc_d = 1'b0;
        dec_d = 1'b0;
        wt_d = tenth ? wt_q + 1'b1 : wt_q;
        case (st_q)
            PSS_IDLE: begin
                wt_d = '0;
                if (up_exp) begin
                    rly_d[0] = 1'b0;
                    sup_d = 1'b1;
                    st_d = PSS_ADD_WAIT1;
                end else if (lo_exp) begin
                    rly_d[0] = 1'b0;
                    if (mode_one_to_three == MODE_CYCLE) begin
                        rly_d[1] = 1'b0;
                        sup_d = 1'b1;
                        st_d = PSS_REM_WAIT;
                    end
                end
            end
            PSS_ADD_WAIT1: begin
                if (wait_done) begin
                    wt_d = '0;
                    if (mode_one_to_three == MODE_CYCLE) begin
                        rly_d[1:0] = 2'h3;
                        sup_d = 1'b0;
                        acc_d = 1'b1;
                        st_d = PSS_IDLE;
                    end else begin
                        rly_d[1] = 1'b1;
                        st_d = PSS_ADD_WAIT2;
                    end
                end
            end
            PSS_ADD_WAIT2: begin
                if (wait_done) begin
                    rly_d[0] = 1'b1;
                    sup_d = 1'b0;
                    acc_d = 1'b1;
                    st_d = PSS_IDLE;
                end
            end
            PSS_REM_WAIT: begin
                if (wait_done) begin
                    rly_d[0] = 1'b1;
                    sup_d = 1'b0;
                    dec_d = 1'b1;
                    st_d = PSS_IDLE;
                end
            end
            default: begin
                st_d = PSS_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_q <= PSS_IDLE;
            wt_q <= '0;
            rly_q <= 3'h1;
            sup_q <= 1'b0;
            acc_q <= 1'b0;
            dec_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wt_q <= wt_d;
            rly_q <= rly_d;
            sup_q <= sup_d;
            acc_q <= acc_d;
            dec_q <= dec_d;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign board_relay_outputs = rly_q;
    // Expansion card relays are never driven by this sequencer.
    assign card_relay_outputs = 4'h0;
    assign output_suppress = sup_q;
    // A falling demand for pressure always wins over acceleration.
    assign accel_req = acc_q && !pressure_above_target;
    assign decel_req = dec_q || (pressure_above_target && !sup_q);
    assign busy = (st_q != PSS_IDLE);

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_add_start;
        @(posedge clk_sys) disable iff (reset) (st_q == PSS_IDLE && up_exp) |=> (!board_relay_outputs[0] && output_suppress);
    endproperty
    a_add_start: assert property (p_add_start) else $error("add did not drop relay 1");
    property p_cycle_add;
        @(posedge clk_sys) disable iff (reset)
            (st_q == PSS_ADD_WAIT1 && wait_done && !mode_one_to_three) |=> (board_relay_outputs[1:0] == 2'h3 && !busy);
    endproperty
    a_cycle_add: assert property (p_cycle_add) else $error("cycle add relays wrong");
    property p_cycle_rem;
        @(posedge clk_sys) disable iff (reset)
            (st_q == PSS_IDLE && !up_exp && lo_exp && !mode_one_to_three) |=> (board_relay_outputs[1:0] == 2'h0);
    endproperty
    a_cycle_rem: assert property (p_cycle_rem) else $error("cycle remove did not drop relays");
    property p_rem_end;
        @(posedge clk_sys) disable iff (reset) (st_q == PSS_REM_WAIT && wait_done) |=> (board_relay_outputs[0] && dec_q);
    endproperty
    a_rem_end: assert property (p_rem_end) else $error("remove end wrong");
    property p_o3_step;
        @(posedge clk_sys) disable iff (reset)
            (st_q == PSS_ADD_WAIT1 && wait_done && mode_one_to_three) |=> (board_relay_outputs[1] && output_suppress);
    endproperty
    a_o3_step: assert property (p_o3_step) else $error("relay 2 step wrong");
    property p_o3_end;
        @(posedge clk_sys) disable iff (reset) (st_q == PSS_ADD_WAIT2 && wait_done) |=> (board_relay_outputs[0] && acc_q);
    endproperty
    a_o3_end: assert property (p_o3_end) else $error("relay 1 not restored");
    property p_press;
        @(posedge clk_sys) disable iff (reset) (pressure_above_target && !output_suppress) |-> (decel_req && !accel_req);
    endproperty
    a_press: assert property (p_press) else $error("no deceleration on high pressure");
    property p_clear;
        @(posedge clk_sys) disable iff (reset) (!at_upper) |=> (up_cnt_q == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("upper dwell not cleared");
    property p_hold;
        @(posedge clk_sys) disable iff (reset) (busy && !wait_done) |=> ($stable(board_relay_outputs) && busy);
    endproperty
    a_hold: assert property (p_hold) else $error("relays changed mid wait");
    property p_card;
        @(posedge clk_sys) disable iff (reset) card_relay_outputs == 4'h0;
    endproperty
    a_card: assert property (p_card) else $error("card relay driven");
endmodule

// ==== bench/pss_contactor_model.sv ====
// Behavioural line_contactor set switched by the staging relay coils.
// Assumes the coils are the sequencer's board_relay_outputs on clk_sys.
`timescale 1ns/100ps
module pss_contactor_model #(
    parameter int ACT_CYCLES = 6
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [2:0] coil,
    output logic [2:0] closed
);
    int cnt [3];
    // A contact moves only after its coil has held for the actuation time.
    // A shorter change-over wait would leave both power paths closed.
    always_ff @(posedge clk_sys or posedge reset) begin
        for (int i = 0; i < 3; i++) begin
            if (reset) begin
                cnt[i] <= 0;
                closed[i] <= 1'b0;
            end else if (coil[i] == closed[i]) begin
                cnt[i] <= 0;
            end else if (cnt[i] >= ACT_CYCLES - 1) begin
                cnt[i] <= 0;
                closed[i] <= coil[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the pump staging relay sequencer.
// Assumes a shortened tenth of four cycles; inputs change at falling edges.
`timescale 1ns/100ps
module testbench;
    import pss_pkg::*;
    localparam int TPT = 4;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic mode_one_to_three = MODE_CYCLE;
    logic [TIME_W-1:0] upper_dwell = DWELL_MIN;
    logic [TIME_W-1:0] lower_dwell = DWELL_MIN;
    logic [TIME_W-1:0] change_wait = 13'h0003;
    logic at_upper = 1'b0;
    logic at_lower = 1'b0;
    logic pressure_above_target = 1'b0;
    logic [2:0] board_relay_outputs;
    logic [2:0] closed;
    logic [3:0] card_relay_outputs;
    logic output_suppress, accel_req, decel_req, busy;
    int errors = 0;
    int cmp_count = 0;
    int n;
    pss_sequencer #(.TICKS_PER_TENTH(TPT)) i_pss_sequencer (.clk_sys(clk_sys), .reset(reset),
        .mode_one_to_three(mode_one_to_three), .upper_dwell(upper_dwell), .lower_dwell(lower_dwell),
        .change_wait(change_wait), .at_upper(at_upper), .at_lower(at_lower),
        .pressure_above_target(pressure_above_target), .board_relay_outputs(board_relay_outputs),
        .card_relay_outputs(card_relay_outputs), .output_suppress(output_suppress),
        .accel_req(accel_req), .decel_req(decel_req), .busy(busy));
    pss_contactor_model i_pss_contactor_model (.clk_sys(clk_sys), .reset(reset),
        .coil(board_relay_outputs), .closed(closed));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic cond(int sel);
        case (sel)
            0: return busy === 1'b1;
            1: return accel_req === 1'b1;
            2: return decel_req === 1'b1;
            3: return board_relay_outputs[1] === 1'b1;
            default: return board_relay_outputs[0] === 1'b0;
        endcase
    endfunction
    task automatic wait_for(int sel, int limit);
        n = 0;
        while (!cond(sel)) begin
            @(negedge clk_sys);
            n++;
            if (n > limit) begin
                errors++;
                $display("ERROR wait %0d expected 1 seen 0", sel);
                close_out();
            end
        end
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_cycle();
        at_upper = 1'b1;
        wait_for(0, 80);
        check("add dwell", 4'h1, {3'h0, n > TPT * upper_dwell});
        check("add drop", 4'h8, {output_suppress, board_relay_outputs});
        wait_for(1, 20);
        check("add wait", 4'h1, {3'h0, n >= TPT * change_wait});
        check("add end", 4'h3, {output_suppress, board_relay_outputs});
        at_upper = 1'b0;
        at_lower = 1'b1;
        wait_for(0, 80);
        check("rem dwell", 4'h1, {3'h0, n > TPT * lower_dwell});
        check("rem drop", 4'h8, {output_suppress, board_relay_outputs});
        wait_for(2, 20);
        check("rem wait", 4'h1, {3'h0, n >= TPT * change_wait});
        check("rem end", 4'h1, {output_suppress, board_relay_outputs});
        at_lower = 1'b0;
    endtask
    task automatic t_one_to_three();
        mode_one_to_three = MODE_ONE_TO_THREE;
        at_upper = 1'b1;
        wait_for(0, 80);
        check("o2t drop", 4'h8, {output_suppress, board_relay_outputs});
        wait_for(3, 20);
        check("o2t wait", 4'h1, {3'h0, n >= TPT * change_wait});
        check("o2t relay2", 4'hA, {output_suppress, board_relay_outputs});
        check("o2t break", 4'h0, {1'b0, closed});
        wait_for(1, 20);
        check("o2t wait2", 4'h1, {3'h0, n >= TPT * change_wait});
        check("o2t relay1", 4'h3, {output_suppress, board_relay_outputs});
        check("o2t contactor", 4'h2, {1'b0, closed});
        at_upper = 1'b0;
        at_lower = 1'b1;
        wait_for(4, 80);
        check("o2t remove", 4'h2, {busy, board_relay_outputs});
        check("card relays", 4'h0, card_relay_outputs);
        at_lower = 1'b0;
    endtask
    task automatic t_dwell_clear();
        repeat (4) begin
            at_upper = 1'b1;
            repeat (30) @(negedge clk_sys);
            at_upper = 1'b0;
            @(negedge clk_sys);
        end
        check("dwell clear", 4'h2, {busy, board_relay_outputs});
        pressure_above_target = 1'b1;
        @(negedge clk_sys);
        check("pressure decel", 4'h1, {3'h0, decel_req});
        pressure_above_target = 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        check("reset relays", 4'h1, {busy | output_suppress, board_relay_outputs});
        t_cycle();
        t_one_to_three();
        t_dwell_clear();
        close_out();
    end
endmodule
